// ---- rtl/periodic_timer_10bit.sv ----
`timescale 1ns/100ps
`default_nettype none
module periodic_timer_10bit
    import ptimer_pkg::*;
(
    input  wire logic        ref_clk,                   // 20 MHz
    input  wire logic        rst,                       // sync, high
    input  wire axi_req_type axi_req,                   // from master
    output var  axi_rsp_type axi_rsp,                   // to master
    input  wire logic        capture_input_pin,         // capture source
    input  wire logic        external_clock_pin,        // alt source
    output logic             timer_output_pin,
    output logic             timer_output_pin_inverted,
    output logic             timer_output_enable        // high: driven
);
    state_type        s_q;        // registered state
    state_type        s_d;        // next state
    logic             on_rise;    // counter_on_bit went high
    logic             running;    // counter advancing
    logic             duty_hit;   // comparator a, valid match
    logic             per_hit;    // comparator p or overflow
    logic             clr_a;      // software clears duty flag
    logic             clr_p;      // software clears period flag
    logic             cap_sel;    // chosen capture source
    logic             cap_edge;   // active capture edge
    logic             wave;       // raw pwm active phase
    logic             active;     // pwm/pulse active request
    logic             do_wr;      // register write this cycle

    // register readback, unimplemented bits are zero
    function automatic logic [31:0] read_reg(
        input logic [ADDR_W-1:0] a,
        input state_type         s
    );
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (a)
            OFS_CTRL0:  begin
                v[ON_BIT]    = s.on;
                v[PAUSE_BIT] = s.pause;
            end
            OFS_CTRL1:  v[7:0] = s.c1;
            OFS_CNT_LO: v[7:0] = s.cnt[7:0];
            OFS_CNT_HI: v[1:0] = s.cnt[CNT_W-1:8];
            OFS_DTY_LO: v[7:0] = s.duty[7:0];
            OFS_DTY_HI: v[1:0] = s.duty[CNT_W-1:8];
            OFS_PER_LO: v[7:0] = s.period[7:0];
            OFS_PER_HI: v[1:0] = s.period[CNT_W-1:8];
            OFS_FLAGS:  begin
                v[FLAG_A_BIT] = s.aflag;
                v[FLAG_P_BIT] = s.pflag;
            end
            default:    v = 32'h0000_0000;
        endcase
        return v;
    endfunction : read_reg

    // known register addresses
    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        return a == OFS_CTRL0 || a == OFS_CTRL1 || a == OFS_CNT_LO ||
               a == OFS_CNT_HI || a == OFS_DTY_LO || a == OFS_DTY_HI ||
               a == OFS_PER_LO || a == OFS_PER_HI || a == OFS_FLAGS;
    endfunction : mapped

    // next-state logic: bus, register writes, counter, output
    always_comb begin
        s_d = s_q;
        // write channels are taken independently
        if (axi_req.awvalid && s_q.rsp.awready) begin
            s_d.aw_held = 1'b1;
            s_d.awaddr  = axi_req.awaddr;
        end
        if (axi_req.wvalid && s_q.rsp.wready) begin
            s_d.w_held = 1'b1;
            s_d.wbyte  = axi_req.wdata[7:0];
            s_d.wlane  = axi_req.wstrb[0];
        end
        if (s_q.rsp.bvalid && axi_req.bready) begin
            s_d.rsp.bvalid = 1'b0;
        end
        do_wr = s_d.aw_held && s_d.w_held && !s_d.rsp.bvalid;
        clr_a = 1'b0;
        clr_p = 1'b0;
        if (do_wr) begin
            s_d.aw_held    = 1'b0;
            s_d.w_held     = 1'b0;
            s_d.rsp.bvalid = 1'b1;
            s_d.rsp.bresp  = mapped(s_d.awaddr) ? RESP_OKAY : RESP_SLVERR;
            if (s_d.wlane) begin
                unique case (s_d.awaddr)
                    OFS_CTRL0:  begin
                        s_d.on    = s_d.wbyte[ON_BIT];
                        s_d.pause = s_d.wbyte[PAUSE_BIT];
                    end
                    OFS_CTRL1:  s_d.c1 = ctrl1_type'(s_d.wbyte);
                    OFS_DTY_LO: s_d.duty[7:0] = s_d.wbyte;
                    OFS_DTY_HI: s_d.duty[CNT_W-1:8] = s_d.wbyte[1:0];
                    OFS_PER_LO: s_d.period[7:0] = s_d.wbyte;
                    OFS_PER_HI: s_d.period[CNT_W-1:8] = s_d.wbyte[1:0];
                    OFS_FLAGS:  begin
                        clr_a = s_d.wbyte[FLAG_A_BIT];
                        clr_p = s_d.wbyte[FLAG_P_BIT];
                    end
                    default:    ;                        // read-only or unmapped
                endcase
            end
        end
        // flags clear first so a same-cycle match sets them again
        if (clr_a) begin
            s_d.aflag = 1'b0;
        end
        if (clr_p) begin
            s_d.pflag = 1'b0;
        end
        // read channel, one read under way at a time
        if (s_q.rsp.rvalid && axi_req.rready) begin
            s_d.rsp.rvalid = 1'b0;
        end
        if (axi_req.arvalid && s_q.rsp.arready) begin
            s_d.rsp.rvalid = 1'b1;
            s_d.rsp.rdata  = read_reg(axi_req.araddr, s_q);
            s_d.rsp.rresp  = mapped(axi_req.araddr) ? RESP_OKAY
                                                    : RESP_SLVERR;
        end
        s_d.rsp.awready = !s_d.aw_held && !s_d.rsp.bvalid;
        s_d.rsp.wready  = !s_d.w_held && !s_d.rsp.bvalid;
        s_d.rsp.arready = !s_d.rsp.rvalid;

        // timer core works from the registered configuration
        on_rise    = s_q.on && !s_q.on_prev;
        s_d.on_prev = s_q.on;
        running    = s_q.on && !s_q.pause && !on_rise;
        // comparators, zero duty is never a match
        duty_hit   = running && s_q.cnt == s_q.duty &&
                     s_q.duty != CNT_ZERO;
        // zero period means clear at the top of the count
        per_hit    = running && (s_q.period == CNT_ZERO ?
                     s_q.cnt == CNT_MAX :
                     s_q.cnt == s_q.period);
        cap_sel    = s_q.c1.cap_src ? external_clock_pin
                                    : capture_input_pin;
        s_d.cap_prev = cap_sel;
        unique case (s_q.c1.out_func)
            CAP_RISE: cap_edge = cap_sel && !s_q.cap_prev;
            CAP_FALL: cap_edge = !cap_sel && s_q.cap_prev;
            CAP_OFF:  cap_edge = 1'b0;
            default:  cap_edge = cap_sel != s_q.cap_prev;
        endcase
        // duty at or above a nonzero period gives full duty
        wave = s_q.cnt < s_q.duty ||
               (s_q.period != CNT_ZERO && s_q.duty >= s_q.period);
        unique case (s_q.c1.out_func)
            OF_INACT: active = 1'b0;
            OF_ACT:   active = 1'b1;
            OF_PWM:   active = wave;
            OF_PULSE: active = s_q.on;
        endcase

        if (on_rise) begin
            s_d.cnt = CNT_ZERO;
            if (s_q.c1.mode == MODE_COMPARE) begin
                s_d.level = s_q.c1.init_level;
            end
        end else if (running) begin
            s_d.cnt = CNT_W'(s_q.cnt + CNT_ONE);
            unique case (s_q.c1.mode)
                MODE_COMPARE, MODE_TIMER: begin
                    if (duty_hit) begin
                        s_d.aflag = 1'b1;
                    end
                    if (s_q.c1.clr_sel) begin
                        if (duty_hit) begin
                            s_d.cnt = CNT_ZERO;
                        end
                    end else if (per_hit) begin
                        s_d.cnt   = CNT_ZERO;
                        s_d.pflag = 1'b1;
                    end
                    // only a duty match moves the pin
                    if (duty_hit && s_q.c1.mode == MODE_COMPARE) begin
                        unique case (s_q.c1.out_func)
                            OF_NONE:   s_d.level = s_q.level;
                            OF_LOW:    s_d.level = 1'b0;
                            OF_HIGH:   s_d.level = 1'b1;
                            OF_TOGGLE: s_d.level = !s_q.level;
                        endcase
                    end
                end
                MODE_PWM: begin
                    if (duty_hit) begin
                        s_d.aflag = 1'b1;
                    end
                    if (s_q.c1.out_func == OF_PULSE) begin
                        // pulse ends on duty match, period unused
                        if (duty_hit) begin
                            s_d.on = 1'b0;
                        end
                    end else if (per_hit) begin
                        s_d.cnt   = CNT_ZERO;
                        s_d.pflag = 1'b1;
                    end
                end
                MODE_CAPTURE: begin
                    if (per_hit) begin
                        s_d.cnt   = CNT_ZERO;
                        s_d.pflag = 1'b1;
                    end
                    if (cap_edge) begin
                        s_d.duty  = s_q.cnt;
                        s_d.aflag = 1'b1;
                    end
                end
            endcase
        end
        // pwm level follows active request and chosen active level
        if (s_q.c1.mode == MODE_PWM) begin
            s_d.level = active ? s_q.c1.init_level
                               : !s_q.c1.init_level;
        end
        // pin pair only driven in the two output modes
        s_d.oe   = s_d.c1.mode == MODE_COMPARE ||
                   s_d.c1.mode == MODE_PWM;
        s_d.pin  = s_d.oe && (s_d.level ^ s_d.c1.invert);
        s_d.pinb = s_d.oe && !(s_d.level ^ s_d.c1.invert);
    end

    // single state register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_q <= STATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flops
    assign axi_rsp                   = s_q.rsp;
    assign timer_output_pin          = s_q.pin;
    assign timer_output_pin_inverted = s_q.pinb;
    assign timer_output_enable       = s_q.oe;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // counter restarts from zero on the on-bit rise
    on_rise_clear_a: assert property (on_rise |=> s_q.cnt == CNT_ZERO)
        else $error("counter not cleared on enable rise");
    // compare mode pin starts at initial level
    init_level_a: assert property (
        on_rise && s_q.c1.mode == MODE_COMPARE
        |=> s_q.level == $past(s_q.c1.init_level))
        else $error("initial level not loaded");
    // timer/counter mode leaves pin undriven
    timer_pin_off_a: assert property (
        s_q.c1.mode == MODE_TIMER |-> !s_q.oe && !s_q.pin)
        else $error("pin driven in timer mode");
    // pin pair equals level through invert bit
    pin_pair_a: assert property (
        s_q.oe |-> s_q.pin == (s_q.level ^ s_q.c1.invert) &&
                   s_q.pinb == !s_q.pin)
        else $error("pin pair polarity wrong");
    // period match clears counter and raises flag
    period_clear_a: assert property (
        running && s_q.c1.mode == MODE_COMPARE && !s_q.c1.clr_sel &&
        s_q.period != CNT_ZERO && s_q.cnt == s_q.period && !clr_p
        |=> s_q.cnt == CNT_ZERO && s_q.pflag)
        else $error("period match clear missing");
    // zero period wraps after top count
    overflow_wrap_a: assert property (
        running && s_q.c1.mode == MODE_TIMER && !s_q.c1.clr_sel &&
        s_q.period == CNT_ZERO && s_q.cnt == CNT_MAX
        |=> s_q.cnt == CNT_ZERO && s_q.pflag)
        else $error("overflow clear missing");
    // clear-select high never raises period flag
    no_pflag_a: assert property (
        s_q.c1.mode == MODE_COMPARE && s_q.c1.clr_sel && !s_q.pflag
        |=> !s_q.pflag)
        else $error("period flag raised with duty clear");
    // zero duty value never raises duty flag
    duty_zero_a: assert property (
        s_q.c1.mode == MODE_COMPARE && s_q.duty == CNT_ZERO &&
        !s_q.aflag |=> !s_q.aflag)
        else $error("duty flag on zero duty");
    // toggle function flips pin on each duty match
    cmp_toggle_a: assert property (
        duty_hit && s_q.c1.mode == MODE_COMPARE &&
        s_q.c1.out_func == OF_TOGGLE |=> s_q.level != $past(s_q.level))
        else $error("toggle missed");
    // pwm active phase shows the active level
    pwm_level_a: assert property (
        s_q.c1.mode == MODE_PWM && s_q.c1.out_func == OF_PWM && wave
        |=> s_q.level == $past(s_q.c1.init_level))
        else $error("pwm active level wrong");
    // duty flag stays until written one
    flag_sticky_a: assert property (
        s_q.aflag && !clr_a |=> s_q.aflag)
        else $error("duty flag lost");

    cov_toggle_c: cover property (duty_hit && s_q.c1.out_func == OF_TOGGLE);
    cov_pwm_c: cover property (s_q.c1.mode == MODE_PWM && per_hit);
    cov_capture_c: cover property (s_q.c1.mode == MODE_CAPTURE && cap_edge);
endmodule : periodic_timer_10bit
`default_nettype wire

// ---- rtl/ptimer_pkg.sv ----
// Summary of operation
// - compare mode: initial-level bit sets pin start
// - pwm/pulse: initial-level bit picks active level
// - timer/counter mode: level and invert ignored
// - invert bit flips the output pin pair
// - capture source: 0 capture pin, 1 clock pin
// - clear on duty match, else period/overflow
// - overflow clear only with period zero
// - clear-select ignored in pwm, pulse, capture
// - counter readable as low byte, high bits
// - duty value as low byte, high bits
// - period value as low byte, high bits
// - mode 00 compare, 11 timer, 10 pwm
// - clear-select 0 raises duty and period flags
// - clear-select 1 never raises period flag
// - zero duty never matches, counter wraps
// - only duty match moves pin, period never
// - output function 00 leaves pin unchanged
// - 01 low, 10 high, 11 toggle on match
// - on-bit rising edge loads initial pin level
// - on rise clears counter, fall holds count
// - timer mode equals compare, pin undriven
// - pwm period clears counter, duty sets width
// - pwm raises both match flags
// - pwm function enables or forces, invert flips
// - pwm function 00 off,01 on,10 pwm,11 pulse
package ptimer_pkg;
    localparam int          CNT_W      = 10;          // counter width
    localparam int          ADDR_W     = 6;           // register address bits
    localparam [CNT_W-1:0]  CNT_ONE    = 10'h001;     // count step
    localparam [CNT_W-1:0]  CNT_ZERO   = 10'h000;     // cleared count
    localparam [CNT_W-1:0]  CNT_MAX    = 10'h3FF;     // wrap point
    // register byte addresses
    localparam [ADDR_W-1:0] OFS_CTRL0  = 6'h00;       // on, pause
    localparam [ADDR_W-1:0] OFS_CTRL1  = 6'h04;       // second control
    localparam [ADDR_W-1:0] OFS_CNT_LO = 6'h08;
    localparam [ADDR_W-1:0] OFS_CNT_HI = 6'h0C;
    localparam [ADDR_W-1:0] OFS_DTY_LO = 6'h10;
    localparam [ADDR_W-1:0] OFS_DTY_HI = 6'h14;
    localparam [ADDR_W-1:0] OFS_PER_LO = 6'h18;
    localparam [ADDR_W-1:0] OFS_PER_HI = 6'h1C;
    localparam [ADDR_W-1:0] OFS_FLAGS  = 6'h20;       // write one to clear
    localparam int          ON_BIT     = 3;           // counter_on_bit
    localparam int          PAUSE_BIT  = 7;           // pause control
    localparam int          FLAG_A_BIT = 0;           // duty_match_flag
    localparam int          FLAG_P_BIT = 1;           // period_match_flag
    localparam [1:0]        RESP_OKAY  = 2'h0;
    localparam [1:0]        RESP_SLVERR = 2'h2;
    // output function codes, compare mode
    localparam [1:0]        OF_NONE    = 2'h0;
    localparam [1:0]        OF_LOW     = 2'h1;
    localparam [1:0]        OF_HIGH    = 2'h2;
    localparam [1:0]        OF_TOGGLE  = 2'h3;
    // output function codes, pwm mode
    localparam [1:0]        OF_INACT   = 2'h0;
    localparam [1:0]        OF_ACT     = 2'h1;
    localparam [1:0]        OF_PWM     = 2'h2;
    localparam [1:0]        OF_PULSE   = 2'h3;
    // capture edge codes
    localparam [1:0]        CAP_RISE   = 2'h0;
    localparam [1:0]        CAP_FALL   = 2'h1;
    localparam [1:0]        CAP_OFF    = 2'h3;

    typedef enum logic [1:0] {
        MODE_COMPARE = 2'b00,
        MODE_CAPTURE = 2'b01,
        MODE_PWM     = 2'b10,
        MODE_TIMER   = 2'b11
    } mode_type;

    // second_control_register layout, bit 7 down to bit 0
    typedef struct packed {
        mode_type   mode;        // mode_field_hi, mode_field_lo
        logic [1:0] out_func;    // output_function_hi/lo
        logic       init_level;  // initial_level_bit
        logic       invert;      // output_invert_bit
        logic       cap_src;     // capture_source_select
        logic       clr_sel;     // clear_select_bit
    } ctrl1_type;

    // axi4-lite master to slave
    typedef struct packed {
        logic [ADDR_W-1:0] awaddr;
        logic              awvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              wvalid;
        logic              bready;
        logic [ADDR_W-1:0] araddr;
        logic              arvalid;
        logic              rready;
    } axi_req_type;

    // axi4-lite slave to master
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic [1:0]  bresp;
        logic        bvalid;
        logic        arready;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        rvalid;
    } axi_rsp_type;

    // whole state of the timer
    typedef struct packed {
        axi_rsp_type       rsp;       // bus answer flops
        logic              aw_held;   // write address taken
        logic [ADDR_W-1:0] awaddr;
        logic              w_held;    // write data taken
        logic [7:0]        wbyte;
        logic              wlane;     // byte lane 0 enabled
        logic              on;        // counter_on_bit
        logic              on_prev;   // for edge detect
        logic              pause;
        ctrl1_type         c1;
        logic [CNT_W-1:0]  cnt;
        logic [CNT_W-1:0]  duty;      // duty_compare_value
        logic [CNT_W-1:0]  period;    // period_compare_value
        logic              aflag;     // duty_match_flag
        logic              pflag;     // period_match_flag
        logic              cap_prev;  // last capture source level
        logic              level;     // internal output level
        logic              pin;       // timer_output_pin
        logic              pinb;      // timer_output_pin_inverted
        logic              oe;        // pin driven
    } state_type;

    localparam state_type STATE_RESET = '0;
endpackage : ptimer_pkg

// ---- test/ptimer_pin_partner.sv ----
`timescale 1ns/100ps
`default_nettype none
// far side of the pins: drives both capture sources
module ptimer_pin_partner (
    input  wire logic cap_lvl,            // level asked by the bench
    output logic      capture_input_pin,  // capture source 0
    output logic      external_clock_pin  // capture source 1
);
    // capture line follows the bench, clock pin idles low
    assign capture_input_pin  = cap_lvl;
    assign external_clock_pin = 1'b0;
endmodule : ptimer_pin_partner
`default_nettype wire

// ---- test/test_periodic_timer_10bit.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_periodic_timer_10bit;
    import ptimer_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rst     = 1'b1;
    logic        cap_lvl = 1'b0;    // capture level to partner
    axi_req_type req     = '0;
    axi_rsp_type rsp;
    logic        pin, pinb, oe, cap_pin, ext_pin;
    int          bad_count = 0;
    int          n_tests   = 0;
    int          cyc       = 0;
    // ctrl1, then oe, level before, level after, flags
    // toggle entry flips twice by the late look, pwm entry is inactive then
    logic [15:0] tbl [13] = '{16'h181B, 16'h2017, 16'h081F, 16'h1919,
        16'h1C17, 16'hD803, 16'h981F, 16'h8813, 16'h8C1F, 16'h381F,
        16'hA81B, 16'h4003, 16'h4202};

    periodic_timer_10bit dut_u (.ref_clk(ref_clk), .rst(rst),
        .axi_req(req), .axi_rsp(rsp), .capture_input_pin(cap_pin),
        .external_clock_pin(ext_pin), .timer_output_pin(pin),
        .timer_output_pin_inverted(pinb), .timer_output_enable(oe));
    ptimer_pin_partner pins_u (.cap_lvl(cap_lvl),
        .capture_input_pin(cap_pin), .external_clock_pin(ext_pin));

    always #25 ref_clk = ~ref_clk;

    // hang guard
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            bad_count++;
            final_report();
        end
    end

    task automatic final_report();
        if (bad_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // one write, address and data offered together
    task automatic wr(input logic [5:0] a, input logic [31:0] v,
                      input logic [1:0] er);
        @(posedge ref_clk);
        req.awaddr  <= a;
        req.awvalid <= 1'b1;
        req.wdata   <= v;
        req.wstrb   <= 4'hF;
        req.wvalid  <= 1'b1;
        req.bready  <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1);
        req.bready <= 1'b0;
        chk({30'h0, rsp.bresp}, {30'h0, er});
    endtask : wr

    task automatic rd(input logic [5:0] a, input logic [31:0] exp,
                      input logic [1:0] er);
        @(posedge ref_clk);
        req.araddr  <= a;
        req.arvalid <= 1'b1;
        req.rready  <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1);
        req.rready <= 1'b0;
        chk(rsp.rdata, exp);
        chk({30'h0, rsp.rresp}, {30'h0, er});
    endtask : rd

    task automatic chk_pins(input logic eo, input logic lv);
        chk({31'h0, oe}, {31'h0, eo});
        chk({31'h0, pin}, {31'h0, lv});
        chk({31'h0, pinb}, {31'h0, eo & ~lv});
    endtask : chk_pins

    // restart in one mode, look at pins before and after a duty match
    task automatic run(input logic [15:0] t);
        cap_lvl <= 1'b0;
        wr(OFS_CTRL0, 32'h0000_0000, RESP_OKAY);
        wr(OFS_FLAGS, 32'h0000_0003, RESP_OKAY);
        wr(OFS_CTRL1, {24'h0, t[15:8]}, RESP_OKAY);
        wr(OFS_CTRL0, 32'h0000_0008, RESP_OKAY);
        repeat (4) @(posedge ref_clk);
        chk_pins(t[4], t[3]);
        cap_lvl <= 1'b1;
        repeat (60) @(posedge ref_clk);
        chk_pins(t[4], t[2]);
        rd(OFS_FLAGS, {30'h0, t[1:0]}, RESP_OKAY);
    endtask : run

    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        // reset values of control, counter and compare registers
        for (int a = 4; a <= 28; a += 4) begin
            rd(a[5:0], 32'h0, RESP_OKAY);
        end
        wr(OFS_DTY_HI, 32'hFFFF_FFFF, RESP_OKAY);
        rd(OFS_DTY_HI, 32'h0000_0003, RESP_OKAY);
        wr(OFS_PER_HI, 32'hFFFF_FFFF, RESP_OKAY);
        rd(OFS_PER_HI, 32'h0000_0003, RESP_OKAY);
        wr(OFS_CNT_LO, 32'h0000_00FF, RESP_OKAY);
        rd(OFS_CNT_LO, 32'h0000_0000, RESP_OKAY);
        rd(6'h24, 32'h0000_0000, RESP_SLVERR);
        // duty 20, period 40
        wr(OFS_DTY_LO, 32'h0000_0014, RESP_OKAY);
        wr(OFS_DTY_HI, 32'h0000_0000, RESP_OKAY);
        wr(OFS_PER_LO, 32'h0000_0028, RESP_OKAY);
        wr(OFS_PER_HI, 32'h0000_0000, RESP_OKAY);
        for (int i = 0; i < 13; i++) begin
            run(tbl[i]);
        end
        // capture-pin rise latched count 4 into duty, clock pin never moved
        rd(OFS_DTY_LO, 32'h0000_0004, RESP_OKAY);
        final_report();
    end
endmodule : test_periodic_timer_10bit
`default_nettype wire
